// ===== rtl/ddsf_pkg.sv
// package: constants for the dual converter sample feed
package ddsf_pkg;
    localparam int SAMPLE_W = 14;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_PTR_W = 3;
    localparam logic [13:0] MID_SCALE = 14'h1fff;
    localparam logic [13:0] CODE_MIN = 14'h0000;
    localparam logic [13:0] CODE_MAX = 14'h3fff;
    localparam int MAX_SAMPLE_CLK_MHZ = 125;
    localparam int CLK_MHZ = 25;
    localparam int PIPE_LATENCY = 3;
    localparam logic [1:0] SRC_OSC = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_INTERCONNECT = 2'h2;
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam int SYNC_STAGES = 2;
endpackage

// ===== rtl/ddsf_stream_if.sv
// interface: valid/ready stream between feed and buffer
`timescale 1ns/1ps
interface ddsf_stream_if #(parameter int W = 28);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ===== rtl/ddsf_fifo.sv
// module: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module ddsf_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // streams
    ddsf_stream_if.dst wr,
    ddsf_stream_if.src rd
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [PTR_W:0] count, next_count;
    logic push, pop;

    assign wr.ready = (count != (PTR_W+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data = mem[rptr];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_comb begin
        next_wptr = push ? PTR_W'(wptr + 1'b1) : wptr;
        next_rptr = pop ? PTR_W'(rptr + 1'b1) : rptr;
        next_count = count;
        if (push && !pop) begin
            next_count = (PTR_W+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (PTR_W+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // storage has no reset; contents are only read when count says valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= wr.data;
        end
    end
endmodule

// ===== rtl/ddsf_top.sv
// module: feeds two 14-bit converter channels from user sample streams
`timescale 1ns/1ps
module ddsf_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // sample clock sources, all from pins
    input wire logic osc_clock_i,
    input wire logic ext_clock_i,
    input wire logic module_interconnect_pins_i,
    input wire logic [1:0] clock_source_i,
    // user samples
    input wire logic sample_valid_a_i,
    input wire logic [13:0] sample_a_i,
    input wire logic sample_valid_b_i,
    input wire logic [13:0] sample_b_i,
    output logic sample_ready_o,
    // converter pins
    output logic [13:0] dac_data_a_o,
    output logic [13:0] dac_data_b_o,
    output logic converter_clock_a_o,
    output logic converter_clock_b_o,
    output logic write_strobe_a_o,
    output logic write_strobe_b_o,
    output logic conversion_trigger_o,
    output logic idle_a_o,
    output logic idle_b_o
);
    localparam int W = ddsf_pkg::SAMPLE_W;

    // two-stage synchronisers for pin clock sources
    logic [2:0] src_meta, src_sync;
    logic src_prev;
    logic sel_level;
    logic next_src_prev;
    logic tick;
    logic [1:0] sel_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= {module_interconnect_pins_i, ext_clock_i, osc_clock_i};
            src_sync <= src_meta;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_q <= ddsf_pkg::SRC_RESET;
        end else begin
            sel_q <= clock_source_i;
        end
    end

    // pick the sample clock; rising edge of the chosen source paces samples
    always_comb begin
        case (sel_q)
            ddsf_pkg::SRC_OSC: sel_level = src_sync[0];
            ddsf_pkg::SRC_EXT: sel_level = src_sync[1];
            ddsf_pkg::SRC_INTERCONNECT: sel_level = src_sync[2];
            default: sel_level = src_sync[0];
        endcase
        next_src_prev = sel_level;
    end
    // sampled against a 25 MHz system clock, the forwarded rate is at most 12.5 MHz
    assign tick = sel_level && !src_prev;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_prev <= 1'b0;
        end else begin
            src_prev <= next_src_prev;
        end
    end

    // both channels travel together so they stay sample-aligned
    ddsf_stream_if #(.W(2*W+2)) in_s ();
    ddsf_stream_if #(.W(2*W+2)) out_s ();

    assign in_s.valid = sample_valid_a_i || sample_valid_b_i;
    assign in_s.data = {sample_valid_b_i, sample_valid_a_i, sample_b_i, sample_a_i};
    assign sample_ready_o = in_s.ready;
    assign out_s.ready = tick;

    ddsf_fifo #(
        .WIDTH(2*W+2),
        .DEPTH(ddsf_pkg::FIFO_DEPTH),
        .PTR_W(ddsf_pkg::FIFO_PTR_W)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .wr(in_s),
        .rd(out_s)
    );

    // pad output registers: at most one load per sample clock edge
    logic [13:0] pad_a, pad_b, next_pad_a, next_pad_b;
    logic strobe_a, strobe_b, next_strobe_a, next_strobe_b;
    logic clk_out, next_clk_out;
    logic take;

    assign take = tick && out_s.valid;

    always_comb begin
        next_pad_a = pad_a;
        next_pad_b = pad_b;
        next_strobe_a = 1'b0;
        next_strobe_b = 1'b0;
        next_clk_out = tick;
        if (take && out_s.data[2*W]) begin
            next_pad_a = out_s.data[W-1:0];
            next_strobe_a = 1'b1;
        end
        if (take && out_s.data[2*W+1]) begin
            next_pad_b = out_s.data[2*W-1:W];
            next_strobe_b = 1'b1;
        end
    end

    // reset to mid-scale so the outputs sit at 0 V
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_a <= ddsf_pkg::MID_SCALE;
            pad_b <= ddsf_pkg::MID_SCALE;
            strobe_a <= 1'b0;
            strobe_b <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            pad_a <= next_pad_a;
            pad_b <= next_pad_b;
            strobe_a <= next_strobe_a;
            strobe_b <= next_strobe_b;
            clk_out <= next_clk_out;
        end
    end

    // converter latches at the next edge and converts one later
    assign dac_data_a_o = pad_a;
    assign dac_data_b_o = pad_b;
    assign converter_clock_a_o = clk_out;
    assign converter_clock_b_o = clk_out;
    assign write_strobe_a_o = strobe_a;
    assign write_strobe_b_o = strobe_b;
    assign conversion_trigger_o = clk_out;
    assign idle_a_o = !out_s.valid;
    assign idle_b_o = !out_s.valid;
endmodule

// ===== test/ddsf_top_assertions.sv
// checker: timing relations at the sample feed pins
`timescale 1ns/1ps
module ddsf_chk (
    // watched pins
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic osc_clock_i,
    input wire logic [1:0] clock_source_i,
    input wire logic [13:0] dac_data_a_o,
    input wire logic [13:0] dac_data_b_o,
    input wire logic converter_clock_a_o,
    input wire logic converter_clock_b_o,
    input wire logic write_strobe_a_o,
    input wire logic write_strobe_b_o,
    input wire logic conversion_trigger_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_osc;
        $rose(osc_clock_i) && clock_source_i == 2'h0 && $past(clock_source_i) == 2'h0;
    endsequence
    sequence s_tick;
        converter_clock_a_o ##1 !converter_clock_a_o;
    endsequence
    a_osc_tick: assert property (s_osc |-> ##[1:5] s_tick)
        else $error("no tick");
    a_tick_single: assert property (converter_clock_a_o |-> s_tick)
        else $error("long tick");
    a_clock_pair: assert property (converter_clock_a_o == converter_clock_b_o)
        else $error("clocks differ");
    a_conversion_trigger_clock: assert property (conversion_trigger_o == converter_clock_a_o)
        else $error("trigger off");
    a_strobe_a: assert property (write_strobe_a_o |-> converter_clock_a_o)
        else $error("strobe a");
    a_strobe_b: assert property (write_strobe_b_o |-> converter_clock_b_o)
        else $error("strobe b");
    a_hold_a: assert property (!$stable(dac_data_a_o) |-> write_strobe_a_o)
        else $error("pad a moved");
    a_hold_b: assert property (!$stable(dac_data_b_o) |-> write_strobe_b_o)
        else $error("pad b moved");
endmodule
bind ddsf_top ddsf_chk u_chk (.*);

// ===== test/ddsf_dac_model.sv
// converter chip model behind the pad pins
`timescale 1ns/1ps
module ddsf_dac_model (
    // pad side
    input wire logic clk_i,
    input wire logic tick_i,
    input wire logic [1:0] strobe_i,
    input wire logic [27:0] pad_i,
    output logic [27:0] level_o
);
    logic [27:0] mask = 28'h0;
    logic [27:0] held = 28'h0;
    logic [27:0] latch = 28'h0;
    // pad word changes with the clock rise, so the chip only takes it at the next rise
    always @(posedge clk_i) begin
        if (tick_i) begin
            mask <= {{14{strobe_i[1]}}, {14{strobe_i[0]}}};
            held <= pad_i;
            latch <= (held & mask) | (latch & ~mask);
            level_o <= latch;
        end
    end
endmodule

// ===== test/ddsf_top_tb.sv
// testbench for the dual converter sample feed
`timescale 1ns/1ps
module ddsf_top_tb;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] pin = 3'h0;
    logic [1:0] sel = 2'h0;
    logic va = 1'b0;
    logic vb = 1'b0;
    logic [13:0] da = 14'h0;
    logic [13:0] db = 14'h0;
    logic rdy, ia, ib, ck, wa, wb;
    logic [13:0] qa, qb;
    logic [27:0] lvl;
    int n_errors = 0;
    int compares = 0;
    ddsf_top u_dut (.clk_i, .resetn_i, .osc_clock_i(pin[0]), .ext_clock_i(pin[1]),
        .module_interconnect_pins_i(pin[2]), .clock_source_i(sel), .sample_valid_a_i(va),
        .sample_a_i(da), .sample_valid_b_i(vb), .sample_b_i(db), .sample_ready_o(rdy),
        .dac_data_a_o(qa), .dac_data_b_o(qb), .converter_clock_a_o(ck),
        .converter_clock_b_o(), .write_strobe_a_o(wa), .write_strobe_b_o(wb),
        .conversion_trigger_o(), .idle_a_o(ia), .idle_b_o(ib));
    ddsf_dac_model u_dac (.clk_i, .tick_i(ck), .strobe_i({wb, wa}), .pad_i({qb, qa}),
        .level_o(lvl));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(string n, logic [27:0] e, logic [27:0] s);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic push(logic [13:0] a, logic [13:0] b, logic vbit);
        @(posedge clk_i);
        va <= 1'b1;
        vb <= vbit;
        da <= a;
        db <= b;
        @(negedge clk_i);
        while (!rdy) @(negedge clk_i);
        @(posedge clk_i);
        va <= 1'b0;
        vb <= 1'b0;
        da <= ~a;
        db <= ~b;
    endtask
    // one source period of 8 clocks, well under the oversampling limit
    task automatic tick(int p);
        @(posedge clk_i);
        pin[p] <= 1'b1;
        repeat (4) @(posedge clk_i);
        pin[p] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_stream();
        for (int i = 0; i < 8; i++) begin
            push(14'(14'h0801 * i), 14'(14'h3fff - 14'h0801 * i), 1'b1);
        end
        @(negedge clk_i);
        chk("full", 3'h0, {rdy, ia, ib});
        for (int k = 1; k <= 10; k++) begin
            tick(0);
            if (k >= 3) chk("level", {14'(14'h3fff - 14'h0801 * (k - 3)), 14'(14'h0801 * (k - 3))}, lvl);
        end
        chk("drained", 2'h3, {ia, ib});
        $display("stream test done");
    endtask
    task automatic t_select();
        logic [13:0] pa;
        logic [13:0] pb;
        pa = qa;
        pb = qb;
        for (int s = 0; s < 3; s++) begin
            sel <= 2'(s);
            push(14'h0100 + 14'(s), 14'h0200 + 14'(s), s != 2);
            tick((s + 1) % 3);
            chk("other pin", {pb, pa}, {qb, qa});
            tick(s);
            pa = 14'h0100 + 14'(s);
            if (s != 2) pb = 14'h0200 + 14'(s);
            chk("chosen pin", {pb, pa}, {qb, qa});
        end
        $display("select test done");
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        chk("reset pads", {2{14'h1fff}}, {qb, qa});
        chk("reset flags", 3'h7, {rdy, ia, ib});
        $display("reset test done");
        t_stream();
        t_select();
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        n_errors++;
        finish_test();
    end
endmodule
